// ### logic/psc_pkg.sv
package psc_pkg;

    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 8;
    localparam int ACT_FLAG_N = 6;

    localparam logic [7:0] SYNC_ACT_STATUS_ADDR = 8'h15;
    localparam logic [7:0] POWER_OUTPUT_CONTROL_ADDR = 8'h26;
    localparam logic [7:0] AUTO_SLEEP_CONFIG_ADDR = 8'h27;

    localparam int PWR_SW_ACTIVE_BIT = 0;
    localparam int PWR_OPTION_LSB = 1;
    localparam int PWR_OPTION_MSB = 2;
    localparam int PWR_PIN_POL_BIT = 3;
    localparam int HIZ_I2S_BIT = 4;
    localparam int HIZ_SPDIF_BIT = 5;
    localparam int HIZ_SLICER_BIT = 6;
    localparam int HIZ_VIDEO_BIT = 7;
    localparam int ACT_FLAG_LSB = 2;
    localparam int ACT_FLAG_MSB = 7;
    localparam int AUTO_SLEEP_EN_BIT = 7;

    localparam logic [7:0] POWER_OUTPUT_CONTROL_RESET = 8'h01;
    localparam logic [7:0] AUTO_SLEEP_CONFIG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        PSC_FULL_POWER = 2'b00,
        PSC_SEEK = 2'b01,
        PSC_AUTO_SLEEP = 2'b10,
        PSC_CMD_POWER_DOWN = 2'b11
    } psc_state_e;

endpackage : psc_pkg

// ### logic/psc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module psc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_syncOut;

    // The first stage feeds only the second stage, so a metastable value never fans out.
    always_comb begin
        next_stage1 = asyncIn;
        next_syncOut = stage1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= '0;
            syncOut <= '0;
        end else begin
            stage1 <= next_stage1;
            syncOut <= next_syncOut;
        end
    end

endmodule : psc_sync

`default_nettype wire

// ### logic/power_state_controller.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - Resolve exactly one of four power states from activity, control bits and pin.
// - Commanded power-down overrides every automatic activity-based decision.
// - Control bit 3 picks the pin's active level; active pin forces power-down.
// - Control bits 2 and 1 select one of four pin power-down options.
// - Bit 0 picks full power-down or outputs high-Z; slicer output exempt.
// - Control bits 7 to 4 individually tri-state video, slicer, SPDIF, I2S outputs.
// - Active with sync gives full power; no sync, auto sleep off gives seek.
// - No sync with auto sleep on keeps only bus, detect, slicer, reference.
// - Bit 0 low powers down to bus, detect, slicer, reference regardless of sync.
// - Software power-down comes from bit 0 of the control register.
// - Sync detect is the OR of the six activity flags at status bits 7:2.
// - Auto sleep enable is bit 7 of configuration register; clear keeps power on.
module power_state_controller (
    input wire logic clk,
    input wire logic rst,
    input wire logic powerDownPin,
    input wire logic [psc_pkg::ACT_FLAG_N-1:0] activityFlags,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [psc_pkg::REG_ADDR_W-1:0] regAddr,
    input wire logic [psc_pkg::REG_DATA_W-1:0] regWrData,
    output logic [psc_pkg::REG_DATA_W-1:0] regRdData,
    output psc_pkg::psc_state_e powerState,
    output logic circuitsOn,
    output logic syncDetect,
    output logic pinPowerDown,
    output logic [1:0] powerDownOption,
    output logic videoOutEn,
    output logic slicerOutEn,
    output logic spdifOutEn,
    output logic i2sOutEn
);

    logic [psc_pkg::REG_DATA_W-1:0] powerOutputControl;
    logic [psc_pkg::REG_DATA_W-1:0] autoSleepConfig;
    logic [psc_pkg::REG_DATA_W-1:0] next_powerOutputControl;
    logic [psc_pkg::REG_DATA_W-1:0] next_autoSleepConfig;
    logic [psc_pkg::REG_DATA_W-1:0] next_regRdData;
    logic [psc_pkg::ACT_FLAG_N:0] syncIn;
    logic [psc_pkg::ACT_FLAG_N:0] syncOut;
    logic pinSync;
    logic [psc_pkg::ACT_FLAG_N-1:0] activitySync;
    logic swPowerDown;
    logic pinActive;
    logic cmdPowerDown;
    logic tristateOnly;
    logic autoSleepEnable;
    logic syncSeen;
    psc_pkg::psc_state_e next_powerState;
    logic next_circuitsOn;
    logic next_syncDetect;
    logic next_pinPowerDown;
    logic [1:0] next_powerDownOption;
    logic outputsLive;
    logic next_videoOutEn;
    logic next_slicerOutEn;
    logic next_spdifOutEn;
    logic next_i2sOutEn;

    assign syncIn = {powerDownPin, activityFlags};

    // The pin and flags come from other clock domains and may change at any time.
    psc_sync #(
        .WIDTH(psc_pkg::ACT_FLAG_N + 1)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .asyncIn(syncIn),
        .syncOut(syncOut)
    );

    assign pinSync = syncOut[psc_pkg::ACT_FLAG_N];
    assign activitySync = syncOut[psc_pkg::ACT_FLAG_N-1:0];

    // Register file: writes and registered read data.
    always_comb begin
        next_powerOutputControl = powerOutputControl;
        next_autoSleepConfig = autoSleepConfig;
        next_regRdData = regRdData;
        if (regWrEn) begin
            if (regAddr == psc_pkg::POWER_OUTPUT_CONTROL_ADDR) begin
                next_powerOutputControl = regWrData;
            end
            if (regAddr == psc_pkg::AUTO_SLEEP_CONFIG_ADDR) begin
                next_autoSleepConfig = regWrData;
            end
        end
        if (regRdEn) begin
            case (regAddr)
                psc_pkg::SYNC_ACT_STATUS_ADDR: begin
                    next_regRdData = {activitySync, 2'h0};
                end
                psc_pkg::POWER_OUTPUT_CONTROL_ADDR: begin
                    next_regRdData = powerOutputControl;
                end
                psc_pkg::AUTO_SLEEP_CONFIG_ADDR: begin
                    next_regRdData = autoSleepConfig;
                end
                default: begin
                    next_regRdData = psc_pkg::UNMAPPED_READ_VALUE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            powerOutputControl <= psc_pkg::POWER_OUTPUT_CONTROL_RESET;
            autoSleepConfig <= psc_pkg::AUTO_SLEEP_CONFIG_RESET;
            regRdData <= psc_pkg::UNMAPPED_READ_VALUE;
        end else begin
            powerOutputControl <= next_powerOutputControl;
            autoSleepConfig <= next_autoSleepConfig;
            regRdData <= next_regRdData;
        end
    end

    // Power state decode and output enables.
    always_comb begin
        swPowerDown = ~powerOutputControl[psc_pkg::PWR_SW_ACTIVE_BIT];
        pinActive = (pinSync == powerOutputControl[psc_pkg::PWR_PIN_POL_BIT]);
        cmdPowerDown = swPowerDown | pinActive;
        // With bit 0 high the pin only floats the outputs and keeps the chip running.
        tristateOnly = pinActive & ~swPowerDown;
        autoSleepEnable = autoSleepConfig[psc_pkg::AUTO_SLEEP_EN_BIT];
        syncSeen = |activitySync;
        if (cmdPowerDown) begin
            next_powerState = psc_pkg::PSC_CMD_POWER_DOWN;
        end else if (syncSeen) begin
            next_powerState = psc_pkg::PSC_FULL_POWER;
        end else if (autoSleepEnable) begin
            next_powerState = psc_pkg::PSC_AUTO_SLEEP;
        end else begin
            next_powerState = psc_pkg::PSC_SEEK;
        end
        case (next_powerState)
            psc_pkg::PSC_FULL_POWER: begin
                next_circuitsOn = 1'b1;
                outputsLive = 1'b1;
            end
            psc_pkg::PSC_SEEK: begin
                next_circuitsOn = 1'b1;
                outputsLive = 1'b1;
            end
            psc_pkg::PSC_AUTO_SLEEP: begin
                next_circuitsOn = 1'b0;
                outputsLive = 1'b0;
            end
            psc_pkg::PSC_CMD_POWER_DOWN: begin
                next_circuitsOn = tristateOnly;
                outputsLive = 1'b0;
            end
            default: begin
                next_circuitsOn = 1'b0;
                outputsLive = 1'b0;
            end
        endcase
        next_syncDetect = syncSeen;
        next_pinPowerDown = pinActive;
        next_powerDownOption =
            powerOutputControl[psc_pkg::PWR_OPTION_MSB:psc_pkg::PWR_OPTION_LSB];
        next_videoOutEn = outputsLive & ~powerOutputControl[psc_pkg::HIZ_VIDEO_BIT];
        next_spdifOutEn = outputsLive & ~powerOutputControl[psc_pkg::HIZ_SPDIF_BIT];
        next_i2sOutEn = outputsLive & ~powerOutputControl[psc_pkg::HIZ_I2S_BIT];
        // The slicer stays powered in every state, so only its own bit floats it.
        next_slicerOutEn = ~powerOutputControl[psc_pkg::HIZ_SLICER_BIT];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            powerState <= psc_pkg::PSC_FULL_POWER;
            circuitsOn <= 1'b1;
            syncDetect <= 1'b0;
            pinPowerDown <= 1'b0;
            powerDownOption <= 2'h0;
            videoOutEn <= 1'b0;
            slicerOutEn <= 1'b0;
            spdifOutEn <= 1'b0;
            i2sOutEn <= 1'b0;
        end else begin
            powerState <= next_powerState;
            circuitsOn <= next_circuitsOn;
            syncDetect <= next_syncDetect;
            pinPowerDown <= next_pinPowerDown;
            powerDownOption <= next_powerDownOption;
            videoOutEn <= next_videoOutEn;
            slicerOutEn <= next_slicerOutEn;
            spdifOutEn <= next_spdifOutEn;
            i2sOutEn <= next_i2sOutEn;
        end
    end

    a_cmd_pd_priority: assert property (@(posedge clk) disable iff (rst)
        !powerOutputControl[0] |=> powerState == psc_pkg::PSC_CMD_POWER_DOWN)
        else $error("Software power-down did not win over activity.");

    a_pin_polarity_pd: assert property (@(posedge clk) disable iff (rst)
        (pinSync == powerOutputControl[3]) |=> powerState == psc_pkg::PSC_CMD_POWER_DOWN
            && pinPowerDown)
        else $error("Active power-down pin did not force power-down.");

    a_full_power_sync: assert property (@(posedge clk) disable iff (rst)
        powerOutputControl[0] && (pinSync != powerOutputControl[3]) && (|activitySync)
        |=> powerState == psc_pkg::PSC_FULL_POWER && circuitsOn)
        else $error("Sync present but not in full power.");

    a_seek_no_auto: assert property (@(posedge clk) disable iff (rst)
        powerOutputControl[0] && (pinSync != powerOutputControl[3]) && !(|activitySync)
        && !autoSleepConfig[7] |=> powerState == psc_pkg::PSC_SEEK && circuitsOn)
        else $error("Lost sync without auto sleep did not stay powered in seek.");

    a_auto_sleep_off: assert property (@(posedge clk) disable iff (rst)
        powerOutputControl[0] && (pinSync != powerOutputControl[3]) && !(|activitySync)
        && autoSleepConfig[7] |=> powerState == psc_pkg::PSC_AUTO_SLEEP && !circuitsOn
            && !videoOutEn)
        else $error("Auto sleep did not power down the core.");

    a_sw_pd_off: assert property (@(posedge clk) disable iff (rst)
        powerState == psc_pkg::PSC_CMD_POWER_DOWN && !$past(powerOutputControl[0])
        |-> !circuitsOn && !spdifOutEn && !i2sOutEn)
        else $error("Software power-down left circuits or outputs on.");

    a_sync_or_flags: assert property (@(posedge clk) disable iff (rst)
        ##1 syncDetect == (|$past(activitySync)))
        else $error("Sync detect is not the OR of the activity flags.");

    a_slicer_exempt: assert property (@(posedge clk) disable iff (rst)
        !powerOutputControl[6] ##1 powerState == psc_pkg::PSC_CMD_POWER_DOWN |-> slicerOutEn)
        else $error("Slicer output floated during power-down.");

    a_video_hiz_bit: assert property (@(posedge clk) disable iff (rst)
        powerOutputControl[7] |=> !videoOutEn)
        else $error("Video outputs driven while their high-Z bit is set.");

    a_pd_option_follow: assert property (@(posedge clk) disable iff (rst)
        regWrEn && regAddr == psc_pkg::POWER_OUTPUT_CONTROL_ADDR
        |=> ##1 powerDownOption == $past(regWrData[2:1], 2))
        else $error("Power-down option does not follow control bits 2 and 1.");

endmodule : power_state_controller

`default_nettype wire

// ### verification/psc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module psc_host_model (
    input wire logic clk,
    input wire logic [7:0] regRdData,
    output logic powerDownPin,
    output logic [5:0] activityFlags,
    output logic regWrEn,
    output logic regRdEn,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData
);
    // Idle bus lines carry the inverse of the last value, so stale data never looks live.
    initial begin
        powerDownPin = 1'b1;
        activityFlags = 6'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        @(posedge clk);
        #1 d = regRdData;
    endtask : rd
    task automatic lines(input logic p, input logic [5:0] f);
        @(posedge clk);
        powerDownPin <= p;
        activityFlags <= f;
    endtask : lines
endmodule : psc_host_model
`default_nettype wire

// ### verification/test_power_state_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_power_state_controller;
    logic clk, rst, pin, wrEn, rdEn;
    logic [5:0] flags;
    logic [7:0] addr, wrData, rdData;
    logic [31:0] r;
    integer seed, nFail, totalChecks;
    psc_pkg::psc_state_e powerState;
    logic circuitsOn, syncDetect, pinPowerDown, videoOutEn, slicerOutEn, spdifOutEn, i2sOutEn;
    logic [1:0] powerDownOption;
    wire logic [10:0] obs;
    assign obs = {powerState, circuitsOn, syncDetect, pinPowerDown, powerDownOption,
        videoOutEn, slicerOutEn, spdifOutEn, i2sOutEn};
    psc_host_model u_host (.clk(clk), .regRdData(rdData), .powerDownPin(pin),
        .activityFlags(flags), .regWrEn(wrEn), .regRdEn(rdEn), .regAddr(addr),
        .regWrData(wrData));
    power_state_controller u_dut (.clk(clk), .rst(rst), .powerDownPin(pin),
        .activityFlags(flags), .regWrEn(wrEn), .regRdEn(rdEn), .regAddr(addr),
        .regWrData(wrData), .regRdData(rdData), .powerState(powerState),
        .circuitsOn(circuitsOn), .syncDetect(syncDetect), .pinPowerDown(pinPowerDown),
        .powerDownOption(powerDownOption), .videoOutEn(videoOutEn),
        .slicerOutEn(slicerOutEn), .spdifOutEn(spdifOutEn), .i2sOutEn(i2sOutEn));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk
    // Commanded power-down (active pin or bit 0 low) wins over everything; sync wins over auto sleep.
    function automatic logic [10:0] expOut(input logic p, input logic [7:0] c,
        input logic [7:0] g, input logic [5:0] f);
        logic act;
        logic [1:0] st;
        logic on;
        act = (p == c[3]);
        if (act || !c[0]) st = 2'b11;
        else if (|f) st = 2'b00;
        else if (g[7]) st = 2'b10;
        else st = 2'b01;
        on = !((st == 2'b10) || (st == 2'b11 && !c[0]));
        return {st, on, |f, act, c[2:1], !st[1] && !c[7], !c[6], !st[1] && !c[5],
            !st[1] && !c[4]};
    endfunction : expOut
    task automatic run(input logic p, input logic [7:0] c, input logic [7:0] g,
        input logic [5:0] f);
        logic [10:0] e;
        logic [7:0] d;
        e = expOut(p, c, g, f);
        u_host.wr(8'h26, c);
        u_host.wr(8'h27, g);
        u_host.wr(8'h15, ~c);
        u_host.lines(p, f);
        // Pin and flags need two edges through the synchroniser and one more through the output registers.
        repeat (4) @(posedge clk);
        #1;
        chk(obs[10:7], e[10:7]);
        chk(obs[6:0], e[6:0]);
        u_host.rd(8'h26, d);
        chk(d, c);
        u_host.rd(8'h15, d);
        chk(d, {f, 2'b00});
        u_host.rd(8'h27, d);
        chk(d[7], g[7]);
    endtask : run
    initial begin
        logic [7:0] d;
        seed = 22;
        nFail = 0;
        totalChecks = 0;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk(obs, 11'h100);
        @(posedge clk);
        rst <= 1'b0;
        u_host.rd(8'h26, d);
        chk(d, 8'h01);
        u_host.rd(8'h27, d);
        chk(d, 8'h00);
        u_host.wr(8'h33, 8'hff);
        u_host.rd(8'h33, d);
        chk(d, 8'h00);
        run(1'b1, 8'h00, 8'h80, 6'h3f);
        run(1'b1, 8'h09, 8'h00, 6'h01);
        run(1'b0, 8'hf1, 8'h00, 6'h20);
        // Random flags are rarely all clear, so seek and auto sleep are forced here.
        run(1'b1, 8'h01, 8'h00, 6'h00);
        run(1'b1, 8'h01, 8'h80, 6'h00);
        run(1'b1, 8'h01, 8'h00, 6'h10);
        for (int i = 0; i < 4; i++) begin
            run(1'b0, {5'h00, i[1:0], 1'b1}, 8'h80, 6'h00);
        end
        for (int k = 0; k < 6; k++) begin
            run(1'b1, 8'h01, 8'h80, 6'h01 << k);
        end
        for (int n = 0; n < 40; n++) begin
            r = $random(seed);
            run(r[0], r[15:8], r[23:16], r[29:24]);
        end
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        end_of_test();
    end
endmodule : test_power_state_controller
`default_nettype wire
